/* File: rtcm_defines.svh */
// Register indices, reset values and timing figures of the calendar clock and monitor
`ifndef RTCM_DEFINES_SVH
`define RTCM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define RTCM_IDX_MON_EN      14'h2002
`define RTCM_IDX_TRIM        14'h2011
`define RTCM_IDX_SEC         14'h2015
`define RTCM_IDX_MIN         14'h2016
`define RTCM_IDX_HOUR        14'h2017
`define RTCM_IDX_WDAY        14'h2018
`define RTCM_IDX_MDAY        14'h2019
`define RTCM_IDX_MONTH       14'h201a
`define RTCM_IDX_YEAR        14'h201b
`define RTCM_IDX_UNLOCK      14'h201f
`define RTCM_IDX_MON_W0      14'h2060
`define RTCM_IDX_MON_W1      14'h2062
`define RTCM_IDX_MON_W2      14'h2064
`define RTCM_IDX_MON_W3      14'h2065

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define RTCM_MON_EN_BIT      3
`define RTCM_MON_EN_RST      1'h0
`define RTCM_TRIM_RST        7'h40
`define RTCM_MON_WORD_RST    10'h000

// ----------------------------------------------------------------------------
// Field limits
// ----------------------------------------------------------------------------
`define RTCM_SEC_MAX         6'h3b
`define RTCM_MIN_MAX         6'h3b
`define RTCM_HOUR_MAX        5'h17
`define RTCM_WDAY_MAX        3'h7
`define RTCM_MONTH_MAX       4'hc
`define RTCM_YEAR_MAX        8'h63

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RTCM_CLK_PERIOD_NS   4
`define RTCM_TB_HZ           32768
`define RTCM_TB_DIV          (1_000_000_000 / (`RTCM_CLK_PERIOD_NS * `RTCM_TB_HZ))

`endif

/* File: rtcm_pkg.sv */
// Types shared by the calendar clock and monitor modules
`default_nettype none
package rtcm_pkg;
  typedef logic [13:0] rtcm_idx_t;
  typedef enum logic [2:0] {
    RTCM_MON_IDLE  = 3'b001,
    RTCM_MON_LOAD  = 3'b010,
    RTCM_MON_SHIFT = 3'b100
  } rtcm_mon_state_e;
endpackage : rtcm_pkg
`default_nettype wire

/* File: rtcm_tick.sv */
// Time base and one-second tick generator
`timescale 1ns/1ns
`default_nettype none
`include "rtcm_defines.svh"
module rtcm_tick #(
  parameter int TB_DIV    = `RTCM_TB_DIV,
  parameter int SUB_TICKS = `RTCM_TB_HZ
) (
  input  wire logic core_clk_in,
  input  wire logic rst_b_in,
  output logic      sec_tick_out
);
  logic [31:0] div_q;
  logic [31:0] sub_q;
  logic        tick_q;

  // ----------------------------------------------------------------------------
  // Time base divider and seconds counter
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_q  <= 32'h0000_0000;
      sub_q  <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (div_q >= 32'(TB_DIV - 1)) begin
        div_q <= 32'h0000_0000;
        if (sub_q >= 32'(SUB_TICKS - 1)) begin
          sub_q  <= 32'h0000_0000;
          tick_q <= 1'b1;
        end else begin
          sub_q <= sub_q + 32'h0000_0001;
        end
      end else begin
        div_q <= div_q + 32'h0000_0001;
      end
    end
  end

  assign sec_tick_out = tick_q;
endmodule : rtcm_tick // rtcm_tick
`default_nettype wire

/* File: rtcm_mon_ser.sv */
// Serialiser for the monitor words
`timescale 1ns/1ns
`default_nettype none
module rtcm_mon_ser
  import rtcm_pkg::*;
#(
  parameter int WORD_W  = 10,
  parameter int N_WORDS = 4
) (
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_b_in,
  input  wire logic                        enable_in,
  input  wire logic [WORD_W*N_WORDS-1:0]   words_in,
  output logic                             serial_out
);
  localparam int TOTAL = WORD_W * N_WORDS;

  rtcm_mon_state_e           state_q;
  logic [TOTAL-1:0]          shreg_q;
  logic [7:0]                cnt_q;
  logic                      ser_q;

  // ----------------------------------------------------------------------------
  // Frame sequencer: word zero first, msb first, looping while enabled
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= RTCM_MON_IDLE;
      shreg_q <= '0;
      cnt_q   <= 8'h00;
      ser_q   <= 1'b0;
    end else if (!enable_in) begin
      state_q <= RTCM_MON_IDLE;
      ser_q   <= 1'b0;
    end else begin
      case (state_q)
        RTCM_MON_IDLE: begin
          state_q <= RTCM_MON_LOAD;
          ser_q   <= 1'b0;
        end
        RTCM_MON_LOAD: begin
          shreg_q <= words_in;
          cnt_q   <= 8'(TOTAL - 1);
          state_q <= RTCM_MON_SHIFT;
          ser_q   <= 1'b0;
        end
        RTCM_MON_SHIFT: begin
          ser_q   <= shreg_q[TOTAL-1];
          shreg_q <= {shreg_q[TOTAL-2:0], 1'b0};
          cnt_q   <= cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            state_q <= RTCM_MON_LOAD;
          end
        end
        default: begin
          state_q <= RTCM_MON_IDLE;
        end
      endcase
    end
  end

  assign serial_out = ser_q;
endmodule : rtcm_mon_ser // rtcm_mon_ser
`default_nettype wire

/* File: rtcm_top.sv */
// Calendar clock and monitor output with a classic Wishbone register slave
//
// Behaviour
// - An unlocked software write to a calendar field loads that field with the written value.
// - Seconds and minutes run 0 to 59 and hours 0 to 23, with 0 as midnight.
// - Weekday runs 1 to 7 with 1 as Sunday, day of month 1 to 31 and month 1 to 12.
// - Year runs 0 to 99 and every year divisible by four, zero included, is a leap year.
// - Chip reset leaves the calendar fields as they were.
// - With monitoring disabled the monitor pin is held low.
// - With monitoring enabled the four 10-bit monitor words are shifted out on the pin.
`timescale 1ns/1ns
`default_nettype none
`include "rtcm_defines.svh"
module rtcm_top
  import rtcm_pkg::*;
#(
  parameter int TB_DIV    = `RTCM_TB_DIV,
  parameter int SUB_TICKS = `RTCM_TB_HZ,
  parameter int MON_W     = 10
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [15:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  output logic             monitor_serial_out
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  logic             ack_q;
  logic [31:0]      rdat_q;
  logic [31:0]      rdat_d;
  rtcm_idx_t        idx;
  logic             req;
  logic             wr;
  logic             time_idx;
  logic             time_wr;
  logic             unlock_q;
  logic             mon_en_q;
  logic [6:0]       trim_q;
  logic [MON_W-1:0] mon_w0_q;
  logic [MON_W-1:0] mon_w1_q;
  logic [MON_W-1:0] mon_w2_q;
  logic [MON_W-1:0] mon_w3_q;
  logic [5:0]       sec_q;
  logic [5:0]       min_q;
  logic [4:0]       hour_q;
  logic [2:0]       wday_q;
  logic [4:0]       mday_q;
  logic [3:0]       month_q;
  logic [7:0]       year_q;
  logic [5:0]       sec_d;
  logic [5:0]       min_d;
  logic [4:0]       hour_d;
  logic [2:0]       wday_d;
  logic [4:0]       mday_d;
  logic [3:0]       month_d;
  logic [7:0]       year_d;
  logic             sec_tick;
  logic             ser;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic is_leap(input logic [7:0] yr);
    is_leap = (yr[1:0] == 2'h0);
  endfunction

  function automatic logic [4:0] days_in_month(input logic [3:0] mo, input logic [7:0] yr);
    case (mo)
      4'h2:                      days_in_month = is_leap(yr) ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb:    days_in_month = 5'h1e;
      default:                   days_in_month = 5'h1f;
    endcase
  endfunction

  function automatic logic [MON_W-1:0] merge_word(input logic [MON_W-1:0] old,
                                                  input logic [31:0] dat,
                                                  input logic [3:0] sel);
    merge_word = old;
    if (sel[0]) begin
      merge_word[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      merge_word[MON_W-1:8] = dat[MON_W-1:8];
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Wishbone slave: ack one cycle after the request, dropped the cycle after
  // ----------------------------------------------------------------------------
  assign idx      = wb_adr_in[15:2];
  assign req      = wb_cyc_in && wb_stb_in;
  assign wr       = req && wb_we_in && ack_q && wb_sel_in[0];
  assign time_idx = (idx >= `RTCM_IDX_SEC) && (idx <= `RTCM_IDX_YEAR);
  assign time_wr  = wr && time_idx && unlock_q;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_comb begin
    rdat_d = 32'h0000_0000;
    case (idx)
      `RTCM_IDX_MON_EN: rdat_d[`RTCM_MON_EN_BIT] = mon_en_q;
      `RTCM_IDX_TRIM:   rdat_d[6:0] = trim_q;
      `RTCM_IDX_SEC:    rdat_d[5:0] = sec_q;
      `RTCM_IDX_MIN:    rdat_d[5:0] = min_q;
      `RTCM_IDX_HOUR:   rdat_d[4:0] = hour_q;
      `RTCM_IDX_WDAY:   rdat_d[2:0] = wday_q;
      `RTCM_IDX_MDAY:   rdat_d[4:0] = mday_q;
      `RTCM_IDX_MONTH:  rdat_d[3:0] = month_q;
      `RTCM_IDX_YEAR:   rdat_d[7:0] = year_q;
      `RTCM_IDX_MON_W0: rdat_d[MON_W-1:0] = mon_w0_q;
      `RTCM_IDX_MON_W1: rdat_d[MON_W-1:0] = mon_w1_q;
      `RTCM_IDX_MON_W2: rdat_d[MON_W-1:0] = mon_w2_q;
      `RTCM_IDX_MON_W3: rdat_d[MON_W-1:0] = mon_w3_q;
      default:          rdat_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdat_q <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;

  // ----------------------------------------------------------------------------
  // Write unlock: one arm per field write, cleared by any other write with byte lane 0 selected
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      unlock_q <= 1'b0;
    end else if (wr) begin
      unlock_q <= (idx == `RTCM_IDX_UNLOCK);
    end
  end

  // ----------------------------------------------------------------------------
  // Control and monitor word registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mon_en_q <= `RTCM_MON_EN_RST;
      trim_q   <= `RTCM_TRIM_RST;
    end else if (wr) begin
      if (idx == `RTCM_IDX_MON_EN) begin
        mon_en_q <= wb_dat_in[`RTCM_MON_EN_BIT];
      end
      if (idx == `RTCM_IDX_TRIM) begin
        trim_q <= wb_dat_in[6:0];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mon_w0_q <= `RTCM_MON_WORD_RST;
      mon_w1_q <= `RTCM_MON_WORD_RST;
      mon_w2_q <= `RTCM_MON_WORD_RST;
      mon_w3_q <= `RTCM_MON_WORD_RST;
    end else if (req && wb_we_in && ack_q) begin
      case (idx)
        `RTCM_IDX_MON_W0: mon_w0_q <= merge_word(mon_w0_q, wb_dat_in, wb_sel_in);
        `RTCM_IDX_MON_W1: mon_w1_q <= merge_word(mon_w1_q, wb_dat_in, wb_sel_in);
        `RTCM_IDX_MON_W2: mon_w2_q <= merge_word(mon_w2_q, wb_dat_in, wb_sel_in);
        `RTCM_IDX_MON_W3: mon_w3_q <= merge_word(mon_w3_q, wb_dat_in, wb_sel_in);
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Calendar advance
  // ----------------------------------------------------------------------------
  rtcm_tick #(
    .TB_DIV    (TB_DIV),
    .SUB_TICKS (SUB_TICKS)
  ) u_tick (
    .core_clk_in  (core_clk_in),
    .rst_b_in     (rst_b_in),
    .sec_tick_out (sec_tick)
  );

  always_comb begin
    sec_d   = sec_q;
    min_d   = min_q;
    hour_d  = hour_q;
    wday_d  = wday_q;
    mday_d  = mday_q;
    month_d = month_q;
    year_d  = year_q;
    if (sec_tick) begin
      if (sec_q >= `RTCM_SEC_MAX) begin
        sec_d = 6'h00;
        if (min_q >= `RTCM_MIN_MAX) begin
          min_d = 6'h00;
          if (hour_q >= `RTCM_HOUR_MAX) begin
            hour_d = 5'h00;
            wday_d = (wday_q >= `RTCM_WDAY_MAX) ? 3'h1 : wday_q + 3'h1;
            if (mday_q >= days_in_month(month_q, year_q)) begin
              mday_d = 5'h01;
              if (month_q >= `RTCM_MONTH_MAX) begin
                month_d = 4'h1;
                year_d  = (year_q >= `RTCM_YEAR_MAX) ? 8'h00 : year_q + 8'h01;
              end else begin
                month_d = month_q + 4'h1;
              end
            end else begin
              mday_d = mday_q + 5'h01;
            end
          end else begin
            hour_d = hour_q + 5'h01;
          end
        end else begin
          min_d = min_q + 6'h01;
        end
      end else begin
        sec_d = sec_q + 6'h01;
      end
    end
  end

  // Calendar fields carry no reset so that a chip reset keeps the time
  always_ff @(posedge core_clk_in) begin
    sec_q   <= (time_wr && idx == `RTCM_IDX_SEC)   ? wb_dat_in[5:0] : sec_d;
    min_q   <= (time_wr && idx == `RTCM_IDX_MIN)   ? wb_dat_in[5:0] : min_d;
    hour_q  <= (time_wr && idx == `RTCM_IDX_HOUR)  ? wb_dat_in[4:0] : hour_d;
    wday_q  <= (time_wr && idx == `RTCM_IDX_WDAY)  ? wb_dat_in[2:0] : wday_d;
    mday_q  <= (time_wr && idx == `RTCM_IDX_MDAY)  ? wb_dat_in[4:0] : mday_d;
    month_q <= (time_wr && idx == `RTCM_IDX_MONTH) ? wb_dat_in[3:0] : month_d;
    year_q  <= (time_wr && idx == `RTCM_IDX_YEAR)  ? wb_dat_in[7:0] : year_d;
  end

  // ----------------------------------------------------------------------------
  // Monitor output
  // ----------------------------------------------------------------------------
  rtcm_mon_ser #(
    .WORD_W  (MON_W),
    .N_WORDS (4)
  ) u_mon (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .enable_in   (mon_en_q),
    .words_in    ({mon_w0_q, mon_w1_q, mon_w2_q, mon_w3_q}),
    .serial_out  (ser)
  );

  assign monitor_serial_out = ser && mon_en_q;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  property p_time_write;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (time_wr && idx == `RTCM_IDX_SEC) |=> (sec_q == $past(wb_dat_in[5:0]));
  endproperty
  a_time_write: assert property (p_time_write) else $error("seconds write not loaded");

  property p_locked_write;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (wr && !unlock_q && idx == `RTCM_IDX_MIN && !sec_tick) |=> $stable(min_q);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("write without unlock changed minutes");

  property p_hour_wrap;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (sec_tick && !time_wr && sec_q == 6'h3b && min_q == 6'h3b && hour_q == 5'h17)
      |=> (sec_q == 6'h00 && min_q == 6'h00 && hour_q == 5'h00);
  endproperty
  a_hour_wrap: assert property (p_hour_wrap) else $error("midnight rollover wrong");

  property p_week_month_wrap;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (sec_tick && !time_wr && sec_q == 6'h3b && min_q == 6'h3b && hour_q == 5'h17
       && wday_q == 3'h7 && month_q == 4'hc && mday_q == 5'h1f)
      |=> (wday_q == 3'h1 && month_q == 4'h1 && mday_q == 5'h01);
  endproperty
  a_week_month_wrap: assert property (p_week_month_wrap) else $error("weekday or month wrap wrong");

  property p_leap_day;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (sec_tick && !time_wr && sec_q == 6'h3b && min_q == 6'h3b && hour_q == 5'h17
       && month_q == 4'h2 && mday_q == 5'h1c)
      |=> (mday_q == (is_leap($past(year_q)) ? 5'h1d : 5'h01));
  endproperty
  a_leap_day: assert property (p_leap_day) else $error("leap year handling wrong");

  // Only fields that already hold a valid time
  property p_reset_keeps;
    @(posedge core_clk_in) disable iff (1'b0)
      (!rst_b_in && sec_q <= `RTCM_SEC_MAX && year_q <= `RTCM_YEAR_MAX)
      |=> (sec_q == $past(sec_q) && year_q == $past(year_q));
  endproperty
  a_reset_keeps: assert property (p_reset_keeps) else $error("reset changed the calendar");

  property p_mon_low;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      !mon_en_q |-> !monitor_serial_out;
  endproperty
  a_mon_low: assert property (p_mon_low) else $error("monitor pin high while disabled");

  property p_mon_first_bit;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      ($rose(mon_en_q) && mon_w0_q[MON_W-1]) ##1 mon_en_q[*2] |=> monitor_serial_out;
  endproperty
  a_mon_first_bit: assert property (p_mon_first_bit) else $error("monitor first bit missing");

  property p_sec_count;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (sec_tick && !time_wr && sec_q < 6'h3b) |=> (sec_q == $past(sec_q) + 6'h01);
  endproperty
  a_sec_count: assert property (p_sec_count) else $error("seconds did not advance");

  c_unlocked_write: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) time_wr);
  c_mon_enabled:    cover property (@(posedge core_clk_in) disable iff (!rst_b_in) monitor_serial_out);
  c_sec_tick:       cover property (@(posedge core_clk_in) disable iff (!rst_b_in) sec_tick);
  c_read_ack:       cover property (@(posedge core_clk_in) disable iff (!rst_b_in) ack_q && !wb_we_in);
  c_day_rollover:   cover property (@(posedge core_clk_in) disable iff (!rst_b_in) sec_tick && mday_d != mday_q);

endmodule : rtcm_top // rtcm_top
`default_nettype wire

/* File: rtcm_top_tb.sv */
// Self-checking testbench of the calendar clock and monitor block
`timescale 1ns/1ns
`default_nettype none
`include "rtcm_defines.svh"
module rtcm_top_tb
  import rtcm_pkg::*;
;
  // ------------------------------------------------------------------
  // Signals and tables
  // ------------------------------------------------------------------
  logic        clk       = 1'b0;
  logic        rst_b     = 1'b0;
  logic        cyc       = 1'b0;
  logic        stb       = 1'b0;
  logic        we        = 1'b0;
  logic [15:0] adr       = 16'h0000;
  logic [3:0]  sel       = 4'h0;
  logic [31:0] dat_w     = 32'h0000_0000;
  logic [31:0] dat_r;
  logic        ack;
  logic        mon;
  int          n_fail    = 0;
  int          cmp_count = 0;

  localparam rtcm_idx_t   F0    = `RTCM_IDX_SEC;
  localparam rtcm_idx_t   UNL   = `RTCM_IDX_UNLOCK;
  localparam rtcm_idx_t   WI[4] = '{`RTCM_IDX_MON_W0, `RTCM_IDX_MON_W1, `RTCM_IDX_MON_W2, `RTCM_IDX_MON_W3};
  localparam logic [39:0] FRAME = {10'h2a5, 10'h0f3, 10'h3c1, 10'h155};

  // Start values sec..year and values one tick later
  logic [7:0] st[4][7] = '{'{8'h3b, 8'h3b, 8'h17, 8'h07, 8'h1c, 8'h02, 8'h04},
                           '{8'h3b, 8'h3b, 8'h17, 8'h03, 8'h1c, 8'h02, 8'h05},
                           '{8'h3b, 8'h3b, 8'h17, 8'h01, 8'h1f, 8'h0c, 8'h63},
                           '{8'h3b, 8'h3b, 8'h17, 8'h02, 8'h1e, 8'h04, 8'h01}};
  logic [7:0] ex[4][7] = '{'{8'h00, 8'h00, 8'h00, 8'h01, 8'h1d, 8'h02, 8'h04},
                           '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h03, 8'h05},
                           '{8'h00, 8'h00, 8'h00, 8'h02, 8'h01, 8'h01, 8'h00},
                           '{8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h05, 8'h01}};

  always #2 clk = ~clk;

  // One second is 100 cycles here
  rtcm_top #(
    .TB_DIV    (10),
    .SUB_TICKS (10),
    .MON_W     (10)
  ) uut (
    .core_clk_in        (clk),
    .rst_b_in           (rst_b),
    .wb_cyc_in          (cyc),
    .wb_stb_in          (stb),
    .wb_we_in           (we),
    .wb_adr_in          (adr),
    .wb_sel_in          (sel),
    .wb_dat_in          (dat_w),
    .wb_dat_out         (dat_r),
    .wb_ack_out         (ack),
    .monitor_serial_out (mon)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic hang();
    n_fail++;
    $display("[FAIL] %0t: wait ran out", $time);
    test_done();
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic xfer(input logic w, input rtcm_idx_t i, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= {i, 2'b00};
    dat_w <= d;
    sel   <= 4'h3;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) hang();
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input rtcm_idx_t i, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, i, d, r);
  endtask

  task automatic rd(input rtcm_idx_t i, output logic [31:0] r);
    xfer(1'b0, i, 32'h0000_0000, r);
  endtask

  task automatic rdc(input rtcm_idx_t i, input logic [31:0] e);
    logic [31:0] r;
    rd(i, r);
    check(r, e);
  endtask

  task automatic calw(input rtcm_idx_t i, input logic [31:0] d);
    wr(UNL, 32'h0000_0000);
    wr(i, d);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_vals();
    check(32'(mon), 32'h0);
    rdc(`RTCM_IDX_MON_EN, 32'h0000_0000);
    rdc(`RTCM_IDX_TRIM, 32'h0000_0040);
    for (int k = 0; k < 4; k++) rdc(WI[k], 32'h0000_0000);
    rdc(UNL, 32'h0000_0000);
    wr(14'h2003, 32'hffff_ffff);
    rdc(14'h2003, 32'h0000_0000);
    wr(`RTCM_IDX_TRIM, 32'hffff_ff95);
    rdc(`RTCM_IDX_TRIM, 32'h0000_0015);
  endtask

  task automatic t_cal_rw();
    calw(F0, 32'h0000_0000);
    for (int k = 1; k < 7; k++) calw(rtcm_idx_t'(F0 + k), 32'(st[1][k]));
    for (int k = 1; k < 7; k++) rdc(rtcm_idx_t'(F0 + k), 32'(st[1][k]));
    wr(F0 + 14'h1, 32'h0000_000a);
    rdc(F0 + 14'h1, 32'h0000_003b);
    wr(UNL, 32'h0000_0000);
    wr(`RTCM_IDX_TRIM, 32'h0000_0040);
    wr(F0 + 14'h1, 32'h0000_000a);
    rdc(F0 + 14'h1, 32'h0000_003b);
    calw(F0 + 14'h1, 32'h0000_000a);
    wr(F0 + 14'h2, 32'h0000_0005);
    rdc(F0 + 14'h1, 32'h0000_000a);
    rdc(F0 + 14'h2, 32'h0000_0017);
  endtask

  task automatic t_roll(input int c);
    logic [31:0] r;
    int n;
    calw(F0, 32'h0000_0000);
    for (int k = 1; k < 7; k++) calw(rtcm_idx_t'(F0 + k), 32'(st[c][k]));
    calw(F0, 32'(st[c][0]));
    n = 0;
    do begin
      rd(F0, r);
      n++;
    end while (r !== 32'h0 && n < 80);
    if (r !== 32'h0) hang();
    for (int k = 1; k < 7; k++) rdc(rtcm_idx_t'(F0 + k), 32'(ex[c][k]));
  endtask

  task automatic t_mon();
    int n;
    for (int k = 0; k < 4; k++) wr(WI[k], 32'(FRAME[39 - 10 * k -: 10]));
    for (int k = 0; k < 4; k++) rdc(WI[k], 32'(FRAME[39 - 10 * k -: 10]));
    repeat (30) begin
      @(posedge clk);
      check(32'(mon), 32'h0);
    end
    wr(`RTCM_IDX_MON_EN, 32'h0000_0008);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (mon !== 1'b1 && n < 10);
    if (mon !== 1'b1) hang();
    check(32'(n), 32'h0000_0004);
    for (int b = 39; b >= 0; b--) begin
      check(32'(mon), 32'(FRAME[b]));
      @(posedge clk);
    end
    check(32'(mon), 32'h0);
    @(posedge clk);
    check(32'(mon), 32'h1);
    rdc(`RTCM_IDX_MON_EN, 32'h0000_0008);
    wr(`RTCM_IDX_MON_EN, 32'h0000_0000);
    repeat (50) begin
      @(posedge clk);
      check(32'(mon), 32'h0);
    end
  endtask

  task automatic t_rst_mid();
    logic [31:0] r;
    wr(`RTCM_IDX_MON_EN, 32'h0000_0008);
    wr(`RTCM_IDX_TRIM, 32'h0000_0011);
    for (int k = 1; k < 7; k++) calw(rtcm_idx_t'(F0 + k), 32'(st[3][k]));
    calw(F0, 32'h0000_001e);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    check(32'(mon), 32'h0);
    rst_b <= 1'b1;
    rd(F0, r);
    check(32'(r == 32'h1e || r == 32'h1f), 32'h1);
    for (int k = 1; k < 7; k++) rdc(rtcm_idx_t'(F0 + k), 32'(st[3][k]));
    rdc(`RTCM_IDX_MON_EN, 32'h0000_0000);
    rdc(`RTCM_IDX_TRIM, 32'h0000_0040);
    rdc(WI[0], 32'h0000_0000);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset_vals();
    t_cal_rw();
    t_roll(0);
    t_roll(1);
    t_roll(2);
    t_roll(3);
    t_mon();
    t_rst_mid();
    test_done();
  end
endmodule // rtcm_top_tb
`default_nettype wire
